/* verilog/ipt_pending_ctrl.v */
`timescale 1ns/1ns
`include "ipt_map.vh"
// interrupt pending/active tracking with software trigger register
module ipt_pending_ctrl #(
  parameter NUM_IRQ = 240
) (
  // clock and reset
  input  wire                     clk_in,
  input  wire                     rst_in,
  // peripheral request lines
  input  wire [NUM_IRQ-1:0]       req_in,
  // processor core service events
  input  wire                     enter_in,
  input  wire [`IPT_NUM_MSB-1:0]  enter_num_in,
  input  wire                     ret_in,
  input  wire [`IPT_NUM_MSB-1:0]  ret_num_in,
  // register port
  input  wire [`IPT_ADDR_W-1:0]   addr_in,
  input  wire [`IPT_WORD_W-1:0]   wdata_in,
  input  wire                     wr_in,
  input  wire                     rd_in,
  input  wire                     priv_in,
  output reg  [`IPT_WORD_W-1:0]   rdata_out,
  // interrupt state
  output wire [NUM_IRQ-1:0]       pend_out,
  output wire [NUM_IRQ-1:0]       act_out,
  output wire                     irq_out
);

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------

  // address falls in an eight-word bank starting at base
  function in_bank;
    input [`IPT_ADDR_W-1:0] a;
    input [`IPT_ADDR_W-1:0] base;
    begin
      in_bank = (a[`IPT_ADDR_W-1:5] == base[`IPT_ADDR_W-1:5]) && (a[1:0] == 2'h0);
    end
  endfunction

  // one-hot vector of an interrupt number; numbers past the top give zero
  function [`IPT_VEC_W-1:0] onehot;
    input [`IPT_NUM_W-1:0] n;
    begin
      onehot = {{(`IPT_VEC_W-1){1'b0}}, 1'b1} << n;
    end
  endfunction

  // a data word placed at its bank position in the full vector
  function [`IPT_VEC_W-1:0] place_word;
    input [`IPT_WORD_W-1:0] w;
    input [2:0]             bank;
    begin
      place_word = {{(`IPT_VEC_W-`IPT_WORD_W){1'b0}}, w} << {bank, 5'h0};
    end
  endfunction

  // the word of a vector that belongs to one bank
  function [`IPT_WORD_W-1:0] pick_word;
    input [`IPT_VEC_W-1:0] v;
    input [2:0]            bank;
    begin
      pick_word = v[{bank, 5'h0} +: `IPT_WORD_W];
    end
  endfunction

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire [2:0]             bank;
  wire                   hit_set;
  wire                   hit_clr;
  wire                   hit_act;
  wire                   hit_mode;
  wire                   hit_trig;
  wire                   hit_ctrl;
  wire                   hit_stat;
  wire                   hit_mask;
  wire                   priv_wr;

  assign bank     = addr_in[4:2];
  assign hit_set  = in_bank(addr_in, `IPT_SET_BASE);
  assign hit_clr  = in_bank(addr_in, `IPT_CLR_BASE);
  assign hit_act  = in_bank(addr_in, `IPT_ACT_BASE);
  assign hit_mode = in_bank(addr_in, `IPT_MODE_BASE);
  assign hit_trig = (addr_in == `IPT_TRIG_ADDR);
  assign hit_ctrl = (addr_in == `IPT_CTRL_ADDR);
  assign hit_stat = (addr_in == `IPT_STAT_ADDR);
  assign hit_mask = (addr_in == `IPT_MASK_ADDR);
  // everything but the trigger register is for privileged code only
  assign priv_wr  = wr_in & priv_in;

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  reg                    permit;
  reg  [`IPT_VEC_W-1:0]  pulse_sel;

  // permit bit and per-interrupt mode (1 = pulse, 0 = level)
  always @(posedge clk_in) begin
    if (rst_in) begin
      permit    <= 1'b0;
      pulse_sel <= {`IPT_VEC_W{1'b0}};
    end else begin
      if (priv_wr && hit_ctrl)
        permit <= wdata_in[`IPT_PERMIT_BIT];
      if (priv_wr && hit_mode)
        pulse_sel[{bank, 5'h0} +: `IPT_WORD_W] <= wdata_in;
    end
  end

  // --------------------------------------------------------------------------
  // software trigger
  // --------------------------------------------------------------------------
  wire [`IPT_NUM_W-1:0]  trig_num;
  wire                   trig_allowed;
  wire                   trig_in_range;
  wire                   trig_ok;
  wire                   trig_bad;

  // upper bits are expected to be zero and are simply not looked at  see (R2)
  assign trig_num      = wdata_in[`IPT_NUM_MSB:0];  // see (R1)
  assign trig_allowed  = priv_in | permit;  // see (R3)
  // both the architectural limit and the built size bound the number
  assign trig_in_range = (trig_num <= `IPT_MAX_IRQ) && ({23'h0, trig_num} < NUM_IRQ);  // see (R19)
  assign trig_ok       = wr_in & hit_trig & trig_allowed & trig_in_range;
  assign trig_bad      = wr_in & hit_trig & ~(trig_allowed & trig_in_range);

  // --------------------------------------------------------------------------
  // per-interrupt event vectors
  // --------------------------------------------------------------------------
  wire [`IPT_VEC_W-1:0]  set_vec;
  wire [`IPT_VEC_W-1:0]  clr_vec;
  wire [`IPT_VEC_W-1:0]  enter_vec;
  wire [`IPT_VEC_W-1:0]  ret_vec;
  wire [`IPT_VEC_W-1:0]  pend_vec;
  wire [`IPT_VEC_W-1:0]  act_vec;
  wire [`IPT_VEC_W-1:0]  edge_vec;
  wire [`IPT_VEC_W-1:0]  impl_vec;

  // ones in a set or clear write select interrupts; zeros leave them alone
  assign set_vec   = ((priv_wr && hit_set) ? place_word(wdata_in, bank) : {`IPT_VEC_W{1'b0}})
                   | (trig_ok ? onehot(trig_num) : {`IPT_VEC_W{1'b0}});  // see (R9)
  assign clr_vec   = (priv_wr && hit_clr) ? place_word(wdata_in, bank)
                                          : {`IPT_VEC_W{1'b0}};  // see (R18)
  assign enter_vec = enter_in ? onehot({1'b0, enter_num_in}) : {`IPT_VEC_W{1'b0}};
  assign ret_vec   = ret_in ? onehot({1'b0, ret_num_in}) : {`IPT_VEC_W{1'b0}};

  // one state cell per implemented interrupt; the rest of the vector reads zero
  genvar gi;
  generate
    for (gi = 0; gi < `IPT_VEC_W; gi = gi + 1) begin : g_irq
      if (gi < NUM_IRQ) begin : g_cell
        ipt_irq_cell u_cell (
          .clk_in        (clk_in),
          .rst_in        (rst_in),
          .req_in        (req_in[gi]),
          .pulse_mode_in (pulse_sel[gi]),
          .set_in        (set_vec[gi]),
          .clr_in        (clr_vec[gi]),
          .enter_in      (enter_vec[gi]),
          .ret_in        (ret_vec[gi]),
          .pend_out      (pend_vec[gi]),
          .act_out       (act_vec[gi]),
          .edge_out      (edge_vec[gi])
        );
        assign impl_vec[gi] = 1'b1;
      end else begin : g_none
        assign pend_vec[gi] = 1'b0;
        assign act_vec[gi]  = 1'b0;
        assign edge_vec[gi] = 1'b0;
        assign impl_vec[gi] = 1'b0;
      end
    end
  endgenerate

  assign pend_out = pend_vec[NUM_IRQ-1:0];
  assign act_out  = act_vec[NUM_IRQ-1:0];

  // --------------------------------------------------------------------------
  // event flags and interrupt
  // --------------------------------------------------------------------------
  wire [`IPT_EV_W-1:0]   events;
  wire [`IPT_EV_W-1:0]   ev_status;
  wire [`IPT_EV_W-1:0]   ev_mask;

  assign events[`IPT_EV_TRIG_OK]  = trig_ok;
  assign events[`IPT_EV_TRIG_BAD] = trig_bad;
  assign events[`IPT_EV_EDGE]     = |edge_vec;

  ipt_event_status u_status (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .event_in   (events),
    .clr_wr_in  (priv_wr & hit_stat),
    .mask_wr_in (priv_wr & hit_mask),
    .wdata_in   (wdata_in[`IPT_EV_W-1:0]),
    .status_out (ev_status),
    .mask_out   (ev_mask),
    .irq_out    (irq_out)
  );

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  reg  [`IPT_WORD_W-1:0] next_rdata;

  // the trigger register is write-only; unmapped and unprivileged reads give zero
  always @* begin
    next_rdata = `IPT_RST_WORD;
    if (rd_in && priv_in) begin
      if (hit_set || hit_clr)
        next_rdata = pick_word(pend_vec, bank);
      else if (hit_act)
        next_rdata = pick_word(act_vec, bank);
      else if (hit_mode)
        next_rdata = pick_word(pulse_sel & impl_vec, bank);
      else if (hit_ctrl)
        next_rdata = {{(`IPT_WORD_W-1){1'b0}}, permit};
      else if (hit_stat)
        next_rdata = {{(`IPT_WORD_W-`IPT_EV_W){1'b0}}, ev_status};
      else if (hit_mask)
        next_rdata = {{(`IPT_WORD_W-`IPT_EV_W){1'b0}}, ev_mask};
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always @(posedge clk_in) begin
    if (rst_in)
      rdata_out <= `IPT_RST_WORD;
    else
      rdata_out <= next_rdata;
  end

endmodule

/* verilog/ipt_map.vh */
// ----------------------------------------------------------------------------
// Overview of operation
// (R1) trigger register write pends the interrupt numbered by bits 8:0, range 0-239
// (R2) software keeps trigger register bits 31:9 at zero
// (R3) unprivileged trigger writes act only while the permit bit is 1
// (R4) pulse requests sampled on the rising clock edge and latched pending
// (R5) peripheral holds a pulse request high for at least one clock
// (R6) level request stays high until the peripheral no longer needs service
// (R7) request high while not active makes the interrupt pending
// (R8) a rising edge on the request line always makes it pending
// (R9) set-pending bit write or trigger write naming it makes it pending
// (R10) entering the service routine clears pending and makes it active
// (R11) level return: pending if request still high, else inactive
// (R12) pulse during service gives active-and-pending, then pending on return
// (R13) no pulse during service: inactive on return
// (R14) level clear-pending: unchanged while request high, else inactive
// (R15) pulse clear-pending: pending to inactive, active-and-pending to active
// (R16) disabled interrupts may still become pending
// (R17) software uses aligned register accesses only
// (R18) clear-pending write never alters the active state; zero bits do nothing
// (R19) trigger numbers outside the implemented range are ignored
// ----------------------------------------------------------------------------
`ifndef IPT_MAP_VH
`define IPT_MAP_VH

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define IPT_ADDR_W      12
`define IPT_WORD_W      32
`define IPT_SET_BASE    12'h200
`define IPT_CLR_BASE    12'h280
`define IPT_ACT_BASE    12'h300
`define IPT_MODE_BASE   12'h380
`define IPT_TRIG_ADDR   12'he00
`define IPT_CTRL_ADDR   12'hf00
`define IPT_STAT_ADDR   12'hf04
`define IPT_MASK_ADDR   12'hf08

// ----------------------------------------------------------------------------
// fields and limits
// ----------------------------------------------------------------------------
`define IPT_VEC_W       256
`define IPT_NUM_W       9
`define IPT_NUM_MSB     8
`define IPT_MAX_IRQ     9'h0ef
`define IPT_PERMIT_BIT  0
`define IPT_EV_W        3
`define IPT_EV_TRIG_OK  0
`define IPT_EV_TRIG_BAD 1
`define IPT_EV_EDGE     2
`define IPT_RST_WORD    32'h00000000
`define IPT_RST_EV      3'h0

`endif

/* verilog/ipt_irq_cell.v */
`timescale 1ns/1ns
// per-interrupt pending/active state
module ipt_irq_cell (
  // clock and reset
  input  wire clk_in,
  input  wire rst_in,
  // request line and mode
  input  wire req_in,
  input  wire pulse_mode_in,
  // software and core events
  input  wire set_in,
  input  wire clr_in,
  input  wire enter_in,
  input  wire ret_in,
  // state
  output wire pend_out,
  output wire act_out,
  output wire edge_out
);

  reg  pend;
  reg  act;
  reg  req_prev;
  reg  next_pend;
  reg  next_act;
  wire rise;

  assign rise     = req_in & ~req_prev;  // see (R4) see (R8)
  assign pend_out = pend;
  assign act_out  = act;
  assign edge_out = rise;

  // next state; set sources are applied last so they win over clears
  always @* begin
    next_pend = pend;
    next_act  = act;
    if (enter_in) begin
      next_pend = 1'b0;  // see (R10)
      next_act  = 1'b1;
    end
    if (ret_in) begin
      next_act = 1'b0;  // see (R13)
      if (!pulse_mode_in)
        next_pend = req_in;  // see (R11)
    end
    // active is left alone by a clear  see (R18)
    if (clr_in && (pulse_mode_in || !req_in))
      next_pend = 1'b0;  // see (R14) see (R15)
    // enable state plays no part here  see (R16)
    if (set_in || rise)
      next_pend = 1'b1;  // see (R9) see (R12)
    if (!pulse_mode_in && req_in && !act && !enter_in)
      next_pend = 1'b1;  // see (R7)
  end

  // state registers
  always @(posedge clk_in) begin
    if (rst_in) begin
      pend     <= 1'b0;
      act      <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      pend     <= next_pend;
      act      <= next_act;
      req_prev <= req_in;
    end
  end

endmodule

/* verilog/ipt_event_status.v */
`timescale 1ns/1ns
`include "ipt_map.vh"
// sticky event flags, mask and level interrupt
module ipt_event_status (
  // clock and reset
  input  wire                 clk_in,
  input  wire                 rst_in,
  // hardware events
  input  wire [`IPT_EV_W-1:0] event_in,
  // software access
  input  wire                 clr_wr_in,
  input  wire                 mask_wr_in,
  input  wire [`IPT_EV_W-1:0] wdata_in,
  // state
  output wire [`IPT_EV_W-1:0] status_out,
  output wire [`IPT_EV_W-1:0] mask_out,
  output wire                 irq_out
);

  reg [`IPT_EV_W-1:0] status;
  reg [`IPT_EV_W-1:0] mask;

  assign status_out = status;
  assign mask_out   = mask;
  assign irq_out    = |(status & mask);

  // write one to clear; an event in the same cycle keeps its bit set
  always @(posedge clk_in) begin
    if (rst_in) begin
      status <= `IPT_RST_EV;
      mask   <= `IPT_RST_EV;
    end else begin
      status <= (status & ~(clr_wr_in ? wdata_in : `IPT_RST_EV)) | event_in;
      if (mask_wr_in)
        mask <= wdata_in;
    end
  end

endmodule

/* tb/ipt_pending_monitor.sv */
`timescale 1ns/1ns
module ipt_pending_monitor #(
  parameter NUM_IRQ = 240
) (
  // clock and reset
  input wire               clk_in,
  input wire               rst_in,
  // requests and core events
  input wire [NUM_IRQ-1:0] req_in,
  input wire               enter_in,
  input wire [7:0]         enter_num_in,
  input wire               ret_in,
  input wire [7:0]         ret_num_in,
  // register port
  input wire [11:0]        addr_in,
  input wire [31:0]        wdata_in,
  input wire               wr_in,
  input wire               rd_in,
  input wire               priv_in,
  input wire [31:0]        rdata_out,
  // state
  input wire [NUM_IRQ-1:0] pend_out,
  input wire [NUM_IRQ-1:0] act_out
);
  // ----------------------------------------------------------------
  // edge helper and properties
  // ----------------------------------------------------------------
  reg  [NUM_IRQ-1:0] prev_req;
  wire [NUM_IRQ-1:0] rise = req_in & ~prev_req;
  // no reset here: a false edge right after reset release would misfire
  always @(posedge clk_in) prev_req <= req_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  trig_pend_a: assert property (wr_in && priv_in && addr_in == 12'he00 &&
    wdata_in[8:0] < 9'h0f0 && wdata_in[8:0] < NUM_IRQ |=> pend_out[$past(wdata_in[8:0])])
    else $error("trigger write left interrupt idle");
  edge_pend_a: assert property (rise != 0 |=>
    (pend_out & $past(rise)) == $past(rise)) else $error("rising edge not latched");
  enter_act_a: assert property (enter_in && enter_num_in < NUM_IRQ |=>
    act_out[$past(enter_num_in)]) else $error("entry did not make active");
  enter_pend_a: assert property (enter_in && enter_num_in < NUM_IRQ &&
    !rise[enter_num_in] && !wr_in && !ret_in |=> !pend_out[$past(enter_num_in)])
    else $error("entry left pending set");
  ret_act_a: assert property (ret_in && ret_num_in < NUM_IRQ &&
    !(enter_in && enter_num_in == ret_num_in) |=> !act_out[$past(ret_num_in)])
    else $error("return left active set");
  clr_act_a: assert property (wr_in && addr_in[11:5] == 7'h14 && !enter_in &&
    !ret_in |=> act_out == $past(act_out)) else $error("clear write moved active");
  act_cause_a: assert property (!enter_in |=>
    (act_out & ~$past(act_out)) == 0) else $error("active rose without entry");
  set_pend_a: assert property (wr_in && priv_in && addr_in == 12'h200 |=>
    (pend_out[31:0] & $past(wdata_in)) == $past(wdata_in)) else $error("set write lost");
  unpriv_rd_a: assert property (rd_in && !priv_in |=> rdata_out == 0)
    else $error("unprivileged read returned data");
  rdata_idle_a: assert property (!rd_in |=> rdata_out == 0)
    else $error("read data outside its cycle");
endmodule
bind ipt_pending_ctrl ipt_pending_monitor #(.NUM_IRQ(NUM_IRQ)) i_ipt_pending_monitor (
  .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .enter_in(enter_in),
  .enter_num_in(enter_num_in), .ret_in(ret_in), .ret_num_in(ret_num_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .priv_in(priv_in), .rdata_out(rdata_out), .pend_out(pend_out), .act_out(act_out));

/* tb/ipt_periph_model.sv */
`timescale 1ns/1ns
module ipt_periph_model #(
  parameter NUM_IRQ = 240
) (
  // clock
  input  wire               clk_in,
  // command: kind 2 pulse, 1 level high, 0 level low
  input  wire               cmd_in,
  input  wire [7:0]         num_in,
  input  wire [1:0]         kind_in,
  // request lines
  output reg  [NUM_IRQ-1:0] req_out = 0
);
  reg [NUM_IRQ-1:0] pulse_q = 0;
  // a pulse lasts exactly one clock, the shortest request allowed
  always @(posedge clk_in) begin
    pulse_q <= 0;
    req_out <= req_out & ~pulse_q;
    if (cmd_in) begin
      if (kind_in[1]) begin
        req_out[num_in] <= 1'b1;
        pulse_q[num_in] <= 1'b1;
      end else begin
        req_out[num_in] <= kind_in[0];
      end
    end
  end
endmodule

/* tb/test_interrupt_pending_trigger.sv */
`timescale 1ns/1ns
module test_interrupt_pending_trigger;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  reg clk_in = 0, rst_in = 1, enter_in = 0, ret_in = 0, wr_in = 0, rd_in = 0;
  reg priv_in = 0, cmd = 0, ick = 0, rd_d = 0;
  reg [7:0] num = 0;
  reg [11:0] addr = 0;
  reg [31:0] wdata = 0, seed;
  reg [255:0] ep = 0, ea = 0;
  reg [8:0] n;
  wire [239:0] req, pend, act;
  wire [31:0] rdata;
  wire irq;
  logic [31:0] q[$], iq[$];
  integer err_total = 0, compares = 0, k;
  // state notes: {active, pending} expected, checked against the output ports
  integer j;
  reg sck = 0;
  reg [511:0] sn;
  logic [511:0] sq[$];
  wire [511:0] seen = {16'h0, act, 16'h0, pend};
  always #10 clk_in = ~clk_in;
  ipt_periph_model #(.NUM_IRQ(240)) i_ipt_periph_model (.clk_in(clk_in), .cmd_in(cmd),
    .num_in(num), .kind_in(wdata[1:0]), .req_out(req));
  ipt_pending_ctrl #(.NUM_IRQ(240)) i_ipt_pending_ctrl (.clk_in(clk_in), .rst_in(rst_in),
    .req_in(req), .enter_in(enter_in), .enter_num_in(num), .ret_in(ret_in),
    .ret_num_in(num), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in),
    .priv_in(priv_in), .rdata_out(rdata), .pend_out(pend), .act_out(act), .irq_out(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      compares = compares + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // every strobe is rewritten each cycle, so no signal gets two writes per edge
  task step(input [5:0] s, input [11:0] a, input [31:0] d, input p);
    begin
      {ick, cmd, ret_in, enter_in, rd_in, wr_in} <= s;
      addr <= a;
      num <= a[7:0];
      wdata <= d;
      priv_in <= p;
      @(posedge clk_in);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    step(6'h01, a, d, 1'b1);  // word-aligned addresses only
  endtask
  task rd(input [11:0] a, input [31:0] e, input p);
    begin
      q.push_back(e);
      step(6'h02, a, 32'h0, p);
    end
  endtask
  task ck_irq(input e);
    begin
      iq.push_back({31'h0, e});
      step(6'h20, 12'h0, 32'h0, 1'b1);
    end
  endtask
  task idle(input integer c);
    repeat (c) step(6'h00, 12'h0, 32'h0, 1'b1);
  endtask
  task chk_all;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rd(12'h200 | {k[2:0], 2'b00}, ep[32*k +: 32], 1'b1);
        rd(12'h300 | {k[2:0], 2'b00}, ea[32*k +: 32], 1'b1);
      end
      // the port view of the state is compared once per check
      sq.push_back({ea, ep});
      sck <= 1'b1;
      idle(1);
      sck <= 1'b0;
      idle(1);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // result watcher: oldest note is matched against each result as it shows
  always @(posedge clk_in) rd_d <= rd_in;
  always @(negedge clk_in) begin
    if (rd_d === 1'b1) chk("rdata", q.pop_front(), rdata);
    if (ick === 1'b1) chk("irq", iq.pop_front(), {31'h0, irq});
    if (sck === 1'b1) begin
      sn = sq.pop_front();
      for (j = 0; j < 8; j = j + 1) begin
        chk("pend_out", sn[32*j +: 32], seen[32*j +: 32]);
        chk("act_out", sn[256+32*j +: 32], seen[256+32*j +: 32]);
      end
    end
  end
  initial begin
    repeat (50000) @(posedge clk_in);
    err_total = err_total + 1;
    summarize;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'd6728;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    idle(1);
    // write-only trigger, unmapped place and control words read zero
    rd(12'he00, 0, 1); rd(12'h7fc, 0, 1); rd(12'hf00, 0, 1); rd(12'hf04, 0, 1);
    rd(12'hf08, 0, 1); rd(12'h380, 0, 1);
    chk_all;
    // status and mask: refused trigger masked, accepted one raises the line
    wr(12'hf08, 32'h1);
    wr(12'he00, 32'd240);
    ck_irq(1'b0);
    wr(12'he00, 32'd5);
    ep[5] = 1'b1;
    ck_irq(1'b1);
    rd(12'h280, 32'h20, 1'b1);
    rd(12'hf04, 32'h3, 1);
    wr(12'hf04, 32'h1);
    ck_irq(1'b0);
    rd(12'hf04, 32'h2, 1);
    wr(12'hf04, 32'h7);
    // random and boundary trigger numbers, out of range ones ignored
    repeat (6) begin
      seed = xs(seed);
      n = 9'(seed % 32'd240);
      wr(12'he00, {23'h0, n});
      ep[n] = 1'b1;
    end
    wr(12'he00, 32'd239);
    wr(12'he00, 32'd0);
    ep[239] = 1'b1;
    ep[0] = 1'b1;
    wr(12'he00, 32'h1ff);
    // unprivileged trigger writes gated by the permit bit; set writes and reads refused
    step(6'h01, 12'he00, 32'd7, 1'b0);
    step(6'h01, 12'h200, 32'h100, 1'b0);
    wr(12'h200, 32'h80);
    ep[7] = 1'b1;
    wr(12'hf00, 32'h1);
    rd(12'hf00, 32'h1, 1);
    step(6'h01, 12'he00, 32'd9, 1'b0);
    ep[9] = 1'b1;
    rd(12'h200, 32'h0, 1'b0);
    wr(12'hf00, 32'h0);
    chk_all;
    for (k = 0; k < 8; k = k + 1) wr(12'h280 | {k[2:0], 2'b00}, 32'hffffffff);
    ep = 0;
    chk_all;
    // level line 10: pend, enter, return while high, clear while high and low
    step(6'h10, 12'd10, 32'h1, 1'b1);
    idle(2);
    ep[10] = 1'b1;
    chk_all;
    step(6'h04, 12'd10, 32'h0, 1'b1);
    ep[10] = 1'b0;
    ea[10] = 1'b1;
    chk_all;
    step(6'h08, 12'd10, 32'h0, 1'b1);
    ep[10] = 1'b1;
    ea[10] = 1'b0;
    chk_all;
    wr(12'h280, 32'h400);
    chk_all; // while the line is high
    step(6'h10, 12'd10, 32'h0, 1'b1);
    idle(2);
    wr(12'h280, 32'h400);
    ep[10] = 1'b0;
    chk_all; // once the line is low
    wr(12'hf08, 32'h4);
    ck_irq(1'b1);
    wr(12'hf04, 32'h7);
    ck_irq(1'b0);
    // pulse line 40 through active-and-pending and both returns
    wr(12'h384, 32'h100);
    rd(12'h384, 32'h100, 1'b1);
    step(6'h10, 12'd40, 32'h2, 1'b1);
    idle(2);
    ep[40] = 1'b1;
    chk_all;
    step(6'h04, 12'd40, 32'h0, 1'b1);
    ep[40] = 1'b0;
    ea[40] = 1'b1;
    chk_all;
    step(6'h10, 12'd40, 32'h2, 1'b1);
    idle(2);
    ep[40] = 1'b1;
    chk_all; // active-and-pending
    wr(12'h284, 32'h100);
    ep[40] = 1'b0;
    chk_all;
    step(6'h10, 12'd40, 32'h2, 1'b1);
    idle(2);
    step(6'h08, 12'd40, 32'h0, 1'b1);
    ep[40] = 1'b1;
    ea[40] = 1'b0;
    chk_all; // pending after return
    wr(12'h284, 32'h100);
    step(6'h04, 12'd40, 32'h0, 1'b1);
    step(6'h08, 12'd40, 32'h0, 1'b1);
    ep[40] = 1'b0;
    chk_all;
    // mid-run reset: pending, permit, mode and status all return to zero
    wr(12'he00, 32'd33);
    wr(12'hf00, 32'h1);
    rst_in <= 1'b1;
    idle(3);
    rst_in <= 1'b0;
    idle(1);
    rd(12'hf00, 32'h0, 1'b1);
    rd(12'hf04, 32'h0, 1'b1);
    rd(12'h384, 32'h0, 1'b1);
    chk_all;
    summarize;
  end
endmodule
